// File: hw/ces_pkg.sv
// Constants, vector numbers and state type for the exception sequencer
package ces_pkg;
  localparam logic [7:0] VEC_POR_PC = 8'h00;
  localparam logic [7:0] VEC_POR_SP = 8'h01;
  localparam logic [7:0] VEC_MR_PC = 8'h02;
  localparam logic [7:0] VEC_MR_SP = 8'h03;
  localparam logic [7:0] VEC_GEN_ILL = 8'h04;
  localparam logic [7:0] VEC_SLOT_ILL = 8'h06;
  localparam logic [7:0] VEC_CPU_AE = 8'h09;
  localparam logic [7:0] VEC_DMA_AE = 8'h0a;
  localparam logic [7:0] VEC_NMI = 8'h0b;
  localparam logic [7:0] VEC_UBRK = 8'h0c;
  localparam logic [31:0] ADDR_POR_PC = 32'h0000_0000;
  localparam logic [31:0] ADDR_POR_SP = 32'h0000_0004;
  localparam logic [31:0] ADDR_MR_PC = 32'h0000_0008;
  localparam logic [31:0] ADDR_MR_SP = 32'h0000_000c;
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam logic [3:0] MASK_MAX = 4'hf;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] FRAME_BYTES = 32'h0000_0008;
  // Source index in the grant vector, 0 is most urgent
  localparam int SRC_CPU_AE = 0;
  localparam int SRC_DMA_AE = 1;
  localparam int SRC_NMI = 2;
  localparam int SRC_UBRK = 3;
  localparam int SRC_EXT = 4;
  localparam int SRC_PER = 5;
  localparam int SRC_INS = 6;
  localparam int NSRC = 7;
  // Instruction class codes from the decoder
  localparam logic [3:0] OP_OTHER = 4'h0;
  localparam logic [3:0] OP_UNDEF = 4'h1;
  localparam logic [3:0] OP_JUMP = 4'h2;
  localparam logic [3:0] OP_JUMP_SUB = 4'h3;
  localparam logic [3:0] OP_REL_JUMP = 4'h4;
  localparam logic [3:0] OP_REL_CALL = 4'h5;
  localparam logic [3:0] OP_CALL_RET = 4'h6;
  localparam logic [3:0] OP_EXC_RET = 4'h7;
  localparam logic [3:0] OP_DSKIP_F = 4'h8;
  localparam logic [3:0] OP_DSKIP_T = 4'h9;
  localparam logic [3:0] OP_FAR_CALL = 4'ha;
  localparam logic [3:0] OP_FAR_JUMP = 4'hb;
  localparam logic [3:0] OP_SKIP_T = 4'hc;
  localparam logic [3:0] OP_SKIP_F = 4'hd;
  localparam logic [3:0] OP_TRAP = 4'he;
  typedef enum logic [2:0] {
    S_HOLD, S_IDLE, S_RV_PC, S_RV_SP, S_PUSH_SR, S_PUSH_PC, S_VEC
  } ces_state_t;
  function automatic logic [31:0] vec_addr(input logic [31:0] base,
                                           input logic [7:0] vec);
    vec_addr = base + {22'h0, vec, 2'b00};
  endfunction : vec_addr
endpackage : ces_pkg

// File: hw/ces_op_class.sv
// Opcode classifier: delayed branch, PC-modifying, undefined, trap
`timescale 1ns/1ps
`default_nettype none
module ces_op_class (
  input wire logic sys_clk, // Clock, for checks only
  input wire logic rst_n, // Synchronised reset
  input wire logic [3:0] op_code, // Decoded class code
  output logic is_delayed, // Opens a delay slot
  output logic is_pc_mod, // Forbidden in a delay slot
  output logic is_undef, // Undefined code
  output logic is_trap // Software trap
);
  assign is_delayed = (op_code == ces_pkg::OP_JUMP) ||
    (op_code == ces_pkg::OP_JUMP_SUB) || (op_code == ces_pkg::OP_REL_JUMP) ||
    (op_code == ces_pkg::OP_REL_CALL) || (op_code == ces_pkg::OP_CALL_RET) ||
    (op_code == ces_pkg::OP_EXC_RET) || (op_code == ces_pkg::OP_DSKIP_F) ||
    (op_code == ces_pkg::OP_DSKIP_T) || (op_code == ces_pkg::OP_FAR_CALL) ||
    (op_code == ces_pkg::OP_FAR_JUMP);
  assign is_pc_mod = is_delayed || (op_code == ces_pkg::OP_SKIP_T) ||
    (op_code == ces_pkg::OP_SKIP_F) || (op_code == ces_pkg::OP_TRAP);
  assign is_undef = (op_code == ces_pkg::OP_UNDEF);
  assign is_trap = (op_code == ces_pkg::OP_TRAP);

  chk_delay_pcmod: assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_delayed |-> is_pc_mod) else $error("delayed branch not PC-modifying");
  chk_skip_nodelay: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (op_code == ces_pkg::OP_SKIP_T) |-> (is_pc_mod && !is_delayed))
    else $error("plain skip opens a delay slot");
endmodule : ces_op_class
`default_nettype wire

// File: hw/ces_prio_pick.sv
// Fixed-priority pick among pending non-reset sources
`timescale 1ns/1ps
`default_nettype none
module ces_prio_pick (
  input wire logic sys_clk, // Clock, for checks only
  input wire logic rst_n, // Synchronised reset
  input wire logic [6:0] req, // Pending sources, bit 0 most urgent
  output logic [6:0] grant, // One-hot winner
  output logic any // Some source pending
);
  logic [6:0] lower_req;
  assign lower_req = req - 7'h01;
  assign grant = req & ~lower_req;
  assign any = |req;

  chk_prio_win: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (req[0] |-> grant == 7'h01) and
    ((req[2] && !req[1] && !req[0]) |-> grant == 7'h04))
    else $error("priority order broken");
endmodule : ces_prio_pick
`default_nettype wire

// File: hw/ces_sequencer.sv
// Exception acceptance and entry sequencer of the CPU
`timescale 1ns/1ps
`default_nettype none
module ces_sequencer (
  input wire logic sys_clk, // CPU clock
  input wire logic rst_b, // Async reset, active low
  input wire logic cold_init_pin_n, // Power-on reset pin
  input wire logic warm_init_pin_n, // Manual reset pin
  input wire logic cpu_addr_err, // CPU address error pulse
  input wire logic dma_addr_err, // DMA address error pulse
  input wire logic nmi_req, // Nonmaskable request level
  input wire logic ubrk_req, // User break request level
  input wire logic ext_req, // External interrupt level
  input wire logic [3:0] ext_level, // Its priority
  input wire logic [7:0] ext_vec, // Its vector number
  input wire logic per_req, // Peripheral interrupt level
  input wire logic [3:0] per_level, // Its priority
  input wire logic [7:0] per_vec, // Its vector number
  input wire logic decode_valid, // Instruction decoded this cycle
  input wire logic [3:0] decode_op, // Its class code
  input wire logic [7:0] trap_imm, // Trap vector number
  input wire logic insn_done, // Executing instruction completes
  input wire logic [31:0] flags_word, // processor_flags_word to save
  input wire logic [31:0] pc_save, // Return PC to save
  input wire logic [31:0] stack_reg_fifteen, // Current stack pointer
  input wire logic mask_wr, // Software write of the mask
  input wire logic [3:0] mask_wr_level, // Mask value written
  output logic mem_req, // Memory access request
  output logic mem_we, // Write when high
  output logic [31:0] mem_addr, // Byte address
  output logic [31:0] mem_wdata, // Write data
  input wire logic mem_ack, // Access done
  input wire logic [31:0] mem_rdata, // Read data with ack
  output logic exc_busy, // Pipeline stall while sequencing
  output logic [6:0] src_ack, // Acceptance pulse per source
  output logic pc_load, // Load pc_value pulse
  output logic [31:0] pc_value, // New PC
  output logic sp_load, // Load sp_value pulse
  output logic [31:0] sp_value, // New stack pointer
  output logic [31:0] vector_table_base, // Vector base
  output logic [3:0] interrupt_level_mask, // Interrupt mask
  output logic cpu_init, // CPU state init pulse
  output logic periph_init // Peripheral init pulse
);
  logic rst_s1_reg, rst_n;
  ces_pkg::ces_state_t state_reg, state_next;
  logic cold_prev_reg, warm_prev_reg, por_mode_reg, slot_reg;
  logic cpu_pend_reg, dma_pend_reg, ins_pend_reg;
  logic [7:0] ins_vec_reg, exc_vec_reg;
  logic is_intr_reg;
  logic [3:0] new_mask_reg;
  logic [31:0] sp_base_reg, pc_fetch_reg, pc_hold_reg;
  logic [31:0] mem_addr_reg, mem_addr_next, mem_wdata_reg, mem_wdata_next;
  logic mem_we_reg, mem_we_next;
  logic pc_load_reg, sp_load_reg, cpu_init_reg, periph_init_reg;
  logic [31:0] pc_value_reg, sp_value_reg, vbr_reg;
  logic [3:0] mask_reg;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  logic is_delayed, is_pc_mod, is_undef, is_trap;
  ces_op_class u_op (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .op_code(decode_op),
    .is_delayed(is_delayed),
    .is_pc_mod(is_pc_mod),
    .is_undef(is_undef),
    .is_trap(is_trap)
  );

  // Reset pin edges
  logic por_start, mr_start, reset_hold, reset_start;
  assign por_start = !cold_prev_reg && cold_init_pin_n;
  assign mr_start = cold_prev_reg && cold_init_pin_n &&
    !warm_prev_reg && warm_init_pin_n;
  assign reset_hold = !cold_init_pin_n || !warm_init_pin_n;
  assign reset_start = por_start || mr_start;

  // Instruction exceptions latched at decode
  logic slot_bad, gen_bad, ins_hit;
  logic [7:0] ins_vec_hit;
  assign slot_bad = slot_reg && (is_undef || is_pc_mod);
  assign gen_bad = !slot_reg && is_undef;
  assign ins_hit = decode_valid && (slot_bad || gen_bad || is_trap);
  assign ins_vec_hit = slot_bad ? ces_pkg::VEC_SLOT_ILL :
    gen_bad ? ces_pkg::VEC_GEN_ILL : trap_imm;

  // Maskable interrupts must beat the current mask
  logic ext_ok, per_ok;
  assign ext_ok = ext_req && (ext_level > mask_reg);
  assign per_ok = per_req && (per_level > mask_reg);
  logic [6:0] req, grant;
  logic any;
  assign req = {ins_pend_reg, per_ok, ext_ok, ubrk_req, nmi_req,
                dma_pend_reg, cpu_pend_reg};
  ces_prio_pick u_prio (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .req(req),
    .grant(grant),
    .any(any)
  );

  // Entry only at an instruction boundary
  logic take;
  assign take = (state_reg == ces_pkg::S_IDLE) && insn_done && any &&
    !reset_start && !reset_hold;
  assign src_ack = take ? grant : 7'h00;
  logic [7:0] take_vec;
  logic [3:0] take_mask;
  assign take_vec = grant[ces_pkg::SRC_CPU_AE] ? ces_pkg::VEC_CPU_AE :
    grant[ces_pkg::SRC_DMA_AE] ? ces_pkg::VEC_DMA_AE :
    grant[ces_pkg::SRC_NMI] ? ces_pkg::VEC_NMI :
    grant[ces_pkg::SRC_UBRK] ? ces_pkg::VEC_UBRK :
    grant[ces_pkg::SRC_EXT] ? ext_vec :
    grant[ces_pkg::SRC_PER] ? per_vec : ins_vec_reg;
  assign take_mask = grant[ces_pkg::SRC_EXT] ? ext_level :
    grant[ces_pkg::SRC_PER] ? per_level : ces_pkg::MASK_MAX;

  logic [31:0] rst_pc_addr, rst_sp_addr;
  assign rst_pc_addr = ces_pkg::vec_addr(ces_pkg::VBR_RESET,
    por_start ? ces_pkg::VEC_POR_PC : ces_pkg::VEC_MR_PC);
  assign rst_sp_addr = ces_pkg::vec_addr(ces_pkg::VBR_RESET,
    por_mode_reg ? ces_pkg::VEC_POR_SP : ces_pkg::VEC_MR_SP);
  // Sequencer; a reset pin aborts any entry in progress
  always_comb begin
    state_next = state_reg;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    mem_we_next = mem_we_reg;
    if (reset_start) begin
      state_next = ces_pkg::S_RV_PC;
      mem_addr_next = rst_pc_addr;
      mem_we_next = 1'b0;
    end else if (reset_hold) begin
      state_next = ces_pkg::S_HOLD;
    end else begin
      unique case (state_reg)
        ces_pkg::S_HOLD: state_next = ces_pkg::S_HOLD;
        ces_pkg::S_IDLE: if (take) begin
          state_next = ces_pkg::S_PUSH_SR;
          mem_addr_next = stack_reg_fifteen - ces_pkg::WORD_BYTES;
          mem_wdata_next = flags_word;
          mem_we_next = 1'b1;
        end
        ces_pkg::S_RV_PC: if (mem_ack) begin
          state_next = ces_pkg::S_RV_SP;
          mem_addr_next = rst_sp_addr;
        end
        ces_pkg::S_RV_SP: if (mem_ack) state_next = ces_pkg::S_IDLE;
        ces_pkg::S_PUSH_SR: if (mem_ack) begin
          state_next = ces_pkg::S_PUSH_PC;
          mem_addr_next = sp_base_reg - ces_pkg::FRAME_BYTES;
          mem_wdata_next = pc_hold_reg;
        end
        ces_pkg::S_PUSH_PC: if (mem_ack) begin
          state_next = ces_pkg::S_VEC;
          mem_addr_next = ces_pkg::vec_addr(vbr_reg, exc_vec_reg);
          mem_we_next = 1'b0;
        end
        ces_pkg::S_VEC: if (mem_ack) state_next = ces_pkg::S_IDLE;
      endcase
    end
  end

  logic rd_done_rst, rd_done_vec;
  assign rd_done_rst = (state_reg == ces_pkg::S_RV_SP) && mem_ack &&
    !reset_start && !reset_hold;
  assign rd_done_vec = (state_reg == ces_pkg::S_VEC) && mem_ack &&
    !reset_start && !reset_hold;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ces_pkg::S_HOLD;
      cold_prev_reg <= 1'b0;
      warm_prev_reg <= 1'b0;
      por_mode_reg <= 1'b0;
      mem_addr_reg <= 32'h0;
      mem_wdata_reg <= 32'h0;
      mem_we_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cold_prev_reg <= cold_init_pin_n;
      warm_prev_reg <= warm_init_pin_n;
      if (reset_start) por_mode_reg <= por_start;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      mem_we_reg <= mem_we_next;
    end
  end

  // Pending flags; a new event wins over the clear of its acceptance
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_pend_reg <= 1'b0;
      dma_pend_reg <= 1'b0;
      ins_pend_reg <= 1'b0;
      ins_vec_reg <= 8'h00;
      slot_reg <= 1'b0;
    end else begin
      cpu_pend_reg <= cpu_addr_err || (cpu_pend_reg && !src_ack[0]);
      dma_pend_reg <= dma_addr_err || (dma_pend_reg && !src_ack[1]);
      if (ins_hit && (!ins_pend_reg || src_ack[6])) begin
        ins_pend_reg <= 1'b1;
        ins_vec_reg <= ins_vec_hit;
      end else if (src_ack[6]) begin
        ins_pend_reg <= 1'b0;
      end
      if (decode_valid) slot_reg <= is_delayed;
    end
  end

  // Entry context and results
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_vec_reg <= 8'h00;
      is_intr_reg <= 1'b0;
      new_mask_reg <= 4'h0;
      sp_base_reg <= 32'h0;
      pc_hold_reg <= 32'h0;
      pc_fetch_reg <= 32'h0;
      pc_load_reg <= 1'b0;
      sp_load_reg <= 1'b0;
      pc_value_reg <= 32'h0;
      sp_value_reg <= 32'h0;
      vbr_reg <= ces_pkg::VBR_RESET;
      mask_reg <= ces_pkg::MASK_MAX;
      cpu_init_reg <= 1'b0;
      periph_init_reg <= 1'b0;
    end else begin
      cpu_init_reg <= reset_start;
      periph_init_reg <= por_start;
      pc_load_reg <= rd_done_rst || rd_done_vec;
      sp_load_reg <= rd_done_rst || rd_done_vec;
      if (take) begin
        exc_vec_reg <= take_vec;
        is_intr_reg <= |grant[ces_pkg::SRC_PER:ces_pkg::SRC_NMI];
        new_mask_reg <= take_mask;
        sp_base_reg <= stack_reg_fifteen;
        pc_hold_reg <= pc_save;
      end
      if ((state_reg == ces_pkg::S_RV_PC) && mem_ack) pc_fetch_reg <= mem_rdata;
      if (mask_wr) mask_reg <= mask_wr_level; // Reset completion and interrupt entry below win
      if (rd_done_rst) begin
        pc_value_reg <= pc_fetch_reg;
        sp_value_reg <= mem_rdata;
        vbr_reg <= ces_pkg::VBR_RESET;
        mask_reg <= ces_pkg::MASK_MAX;
      end
      if (rd_done_vec) begin
        pc_value_reg <= mem_rdata;
        sp_value_reg <= sp_base_reg - ces_pkg::FRAME_BYTES;
        if (is_intr_reg) mask_reg <= new_mask_reg;
      end
    end
  end

  assign mem_req = (state_reg != ces_pkg::S_HOLD) &&
    (state_reg != ces_pkg::S_IDLE);
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign exc_busy = state_reg != ces_pkg::S_IDLE;
  assign pc_load = pc_load_reg;
  assign pc_value = pc_value_reg;
  assign sp_load = sp_load_reg;
  assign sp_value = sp_value_reg;
  assign vector_table_base = vbr_reg;
  assign interrupt_level_mask = mask_reg;
  assign cpu_init = cpu_init_reg;
  assign periph_init = periph_init_reg;

  chk_por_fetch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    por_start |=> (state_reg == ces_pkg::S_RV_PC) &&
      (mem_addr_reg == ces_pkg::ADDR_POR_PC) && periph_init_reg)
    else $error("power-on reset entry wrong");
  chk_mr_fetch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mr_start && !por_start) |=> (mem_addr_reg == ces_pkg::ADDR_MR_PC) &&
      cpu_init_reg && !periph_init_reg)
    else $error("manual reset entry wrong");
  chk_sp_fetch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ces_pkg::S_RV_SP) |-> (mem_addr_reg == (por_mode_reg ?
      ces_pkg::ADDR_POR_SP : ces_pkg::ADDR_MR_SP)))
    else $error("stack vector address wrong");
  chk_reset_finish: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_done_rst |=> pc_load_reg && (vbr_reg == ces_pkg::VBR_RESET) &&
      (mask_reg == ces_pkg::MASK_MAX) && (pc_value_reg == $past(pc_fetch_reg)))
    else $error("reset completion wrong");
  chk_entry_boundary: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((state_reg == ces_pkg::S_IDLE) && (state_next == ces_pkg::S_PUSH_SR))
      |-> insn_done) else $error("entry off the boundary");
  chk_push_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ces_pkg::S_PUSH_PC) |-> mem_we_reg &&
      (mem_addr_reg == sp_base_reg - ces_pkg::FRAME_BYTES) &&
      (mem_wdata_reg == pc_hold_reg)) else $error("PC push wrong");
  chk_vec_base: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ces_pkg::S_VEC) |-> !mem_we_reg &&
      (mem_addr_reg == ces_pkg::vec_addr(vbr_reg, exc_vec_reg)))
    else $error("vector address wrong");
  chk_slot_ill: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (decode_valid && slot_reg && is_undef && !ins_pend_reg) |=>
      ins_pend_reg && (ins_vec_reg == ces_pkg::VEC_SLOT_ILL))
    else $error("slot illegal missed");
  chk_gen_ill: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (decode_valid && !slot_reg && is_undef && !ins_pend_reg) |=>
      ins_pend_reg && (ins_vec_reg == ces_pkg::VEC_GEN_ILL))
    else $error("general illegal missed");
  chk_pend_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dma_pend_reg && !src_ack[1]) |=> dma_pend_reg)
    else $error("pending source dropped");
endmodule : ces_sequencer
`default_nettype wire

// File: testbench/ces_mem_model.sv
// Memory model answering vector fetches and stack pushes
`timescale 1ns/1ps
`default_nettype none
module ces_mem_model (
  input wire logic sys_clk, // CPU clock
  input wire logic [1:0] wait_n, // Wait cycles before ack
  input wire logic mem_req, // Access request
  input wire logic mem_we, // Write when high
  input wire logic [31:0] mem_addr, // Byte address
  input wire logic [31:0] mem_wdata, // Write data
  output logic mem_ack, // Access done
  output logic [31:0] mem_rdata // Read data
);
  logic [31:0] mem [0:255];
  logic [1:0] cnt_reg = 2'h0;
  logic [31:0] last_reg = 32'h0;
  assign mem_ack = mem_req && (cnt_reg == wait_n);
  // Scrambled off-ack data, so a late sample cannot pass
  assign mem_rdata = mem_ack ? mem[mem_addr[9:2]] : ~last_reg;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 32'h0000_1000 + 32'(i * 16);
    end
  end
  always @(posedge sys_clk) begin
    if (mem_ack) begin
      cnt_reg <= 2'h0;
      last_reg <= mem_rdata;
      if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
    end else if (mem_req) cnt_reg <= cnt_reg + 2'h1;
    else cnt_reg <= 2'h0;
  end
endmodule : ces_mem_model
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench of the exception sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0, rst_b = 1'b0, cold_init_pin_n = 1'b1;
  logic warm_init_pin_n = 1'b1, cpu_addr_err = 1'b0, dma_addr_err = 1'b0;
  logic nmi_req = 1'b0, ubrk_req = 1'b0, ext_req = 1'b0, per_req = 1'b0;
  logic decode_valid = 1'b0, insn_done = 1'b0;
  logic [3:0] ext_level = 4'hf, per_level = 4'hf, decode_op = 4'h0;
  logic [7:0] ext_vec = 8'h40, per_vec = 8'h48, trap_imm = 8'h21;
  logic [31:0] flags_word = 32'h0000_00f0, pc_save = 32'h0000_0400;
  logic [31:0] stack_reg_fifteen = 32'h0000_0200;
  logic [1:0] wait_n = 2'h0;
  logic mem_req, mem_we, mem_ack, exc_busy, pc_load, sp_load;
  logic cpu_init, periph_init, mask_wr = 1'b0;
  logic [3:0] mask_wr_level = 4'h3, exp_mask = 4'hf;
  int per_cnt = 0, cpu_cnt = 0, per_base = 0, cpu_base = 0;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, pc_value, sp_value;
  logic [31:0] vector_table_base;
  logic [6:0] src_ack;
  logic [3:0] interrupt_level_mask;
  int num_errors = 0;
  int compares = 0;
  always #20 sys_clk = ~sys_clk;
  ces_sequencer ces_sequencer_inst (.sys_clk, .rst_b, .cold_init_pin_n,
    .warm_init_pin_n, .cpu_addr_err, .dma_addr_err, .nmi_req, .ubrk_req,
    .ext_req, .ext_level, .ext_vec, .per_req, .per_level, .per_vec,
    .decode_valid, .decode_op, .trap_imm, .insn_done, .flags_word,
    .pc_save, .stack_reg_fifteen, .mask_wr, .mask_wr_level, .mem_req,
    .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata, .exc_busy, .src_ack, .pc_load, .pc_value,
    .sp_load, .sp_value, .vector_table_base, .interrupt_level_mask,
    .cpu_init, .periph_init);
  ces_mem_model mem_model_inst (.sys_clk, .wait_n, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  always @(posedge sys_clk) begin
    if (periph_init === 1'b1) per_cnt <= per_cnt + 1;
    if (cpu_init === 1'b1) cpu_cnt <= cpu_cnt + 1;
  end
  task automatic check_word(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_flag(string what, logic exp, logic got);
    check_word(what, {31'h0, exp}, {31'h0, got});
  endtask : check_flag
  task automatic complete_run();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic await_entry(logic [31:0] pc, logic [31:0] sp);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (pc_load !== 1'b1 && n < 60);
    check_flag("pc_load", 1'b1, pc_load);
    check_word("pc_value", pc, pc_value);
    check_word("sp_value", sp, sp_value);
    check_word("base", 32'h0, vector_table_base);
    check_word("mask", {28'h0, exp_mask},
      {28'h0, interrupt_level_mask});
  endtask : await_entry
  task automatic pin_pulse(logic manual);
    @(negedge sys_clk);
    per_base = per_cnt;
    cpu_base = cpu_cnt;
    if (manual) warm_init_pin_n = 1'b0;
    else cold_init_pin_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    warm_init_pin_n = 1'b1;
    cold_init_pin_n = 1'b1;
  endtask : pin_pulse
  task automatic decode(logic [3:0] op);
    @(negedge sys_clk);
    decode_valid = 1'b1;
    decode_op = op;
  endtask : decode
  task automatic boundary(int src);
    @(negedge sys_clk);
    decode_valid = 1'b0;
    insn_done = 1'b1;
    #1;
    check_word("src_ack", src < 0 ? 32'h0 : 32'(1 << src),
      32'(src_ack));
    @(negedge sys_clk);
    insn_done = 1'b0;
    if (src == 2) nmi_req = 1'b0;
    if (src == 3) ubrk_req = 1'b0;
  endtask : boundary
  task automatic take(int src, logic [7:0] vec);
    boundary(src);
    await_entry(32'h1000 + {20'h0, vec, 4'h0}, stack_reg_fifteen - 32'h8);
    check_word("saved flags", flags_word, mem_model_inst.mem[8'h7f]);
    check_word("saved pc", pc_save, mem_model_inst.mem[8'h7e]);
    pc_save = pc_save + 32'h4;
  endtask : take
  initial begin
    #800000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    rst_b = 1'b1;
    await_entry(32'h1000, 32'h1010);
    pin_pulse(1'b0);
    await_entry(32'h1000, 32'h1010);
    check_word("periph_init", 32'h1, 32'(per_cnt - per_base));
    pin_pulse(1'b1);
    await_entry(32'h1020, 32'h1030);
    check_word("periph_init", 32'h0, 32'(per_cnt - per_base));
    check_word("cpu_init", 32'h1, 32'(cpu_cnt - cpu_base));
    // Warm rise while cold is low must not start a manual reset
    @(negedge sys_clk);
    per_base = per_cnt;
    cpu_base = cpu_cnt;
    cold_init_pin_n = 1'b0;
    warm_init_pin_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    warm_init_pin_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    cold_init_pin_n = 1'b1;
    await_entry(32'h1000, 32'h1010);
    check_word("periph_init", 32'h1, 32'(per_cnt - per_base));
    check_word("cpu_init", 32'h1, 32'(cpu_cnt - cpu_base));
    wait_n = 2'h2;
    @(negedge sys_clk);
    {cpu_addr_err, dma_addr_err, nmi_req, ubrk_req, ext_req} = 5'h1f;
    decode_valid = 1'b1;
    decode_op = ces_pkg::OP_UNDEF;
    @(negedge sys_clk);
    {cpu_addr_err, dma_addr_err} = 2'h0;
    repeat (3) @(negedge sys_clk);
    check_flag("exc_busy", 1'b0, exc_busy);
    check_word("src_ack", 32'h0, 32'(src_ack));
    take(0, ces_pkg::VEC_CPU_AE);
    take(1, ces_pkg::VEC_DMA_AE);
    take(2, ces_pkg::VEC_NMI);
    take(3, ces_pkg::VEC_UBRK);
    take(6, ces_pkg::VEC_GEN_ILL);
    boundary(-1);
    ext_req = 1'b0;
    wait_n = 2'h0;
    decode(ces_pkg::OP_TRAP);
    take(6, 8'h21);
    for (int f = 1; f <= 14; f++) begin
      decode(ces_pkg::OP_OTHER);
      decode(4'(2 + f % 10));
      decode(4'(f));
      take(6, ces_pkg::VEC_SLOT_ILL);
    end
    for (int d = 2; d <= 11; d++) begin
      decode(4'(d));
      decode(ces_pkg::OP_OTHER);
      boundary(-1);
    end
    for (int k = 0; k < 3; k++) begin
      decode(k == 0 ? ces_pkg::OP_OTHER : 4'(4'hb + k));
      decode(ces_pkg::OP_UNDEF);
      take(6, ces_pkg::VEC_GEN_ILL);
    end
    // Maskable sources need a level above the mask software wrote
    @(negedge sys_clk);
    mask_wr = 1'b1;
    {ext_req, per_req, ext_level, per_level} = {2'h3, 4'h5, 4'h4};
    @(negedge sys_clk);
    mask_wr = 1'b0;
    exp_mask = 4'h5;
    take(4, 8'h40);
    @(negedge sys_clk);
    ext_req = 1'b0;
    mask_wr = 1'b1;
    exp_mask = 4'h4;
    @(negedge sys_clk);
    mask_wr = 1'b0;
    take(5, 8'h48);
    per_req = 1'b0;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
